//--- core/pdcm_pkg.sv
// Purpose: Shared constants and types for the peripheral DMA bridge
// Assumes: 16-bit words, byte addresses, word-aligned DMA
// Notes: Relocation base is a simple page offset when enabled
package pdcm_pkg;
  localparam int PDCM_PA_W = 18;
  localparam int PDCM_MA_W = 22;
  localparam int PDCM_DW = 16;
  localparam int PDCM_SETS = 4;
  localparam int PDCM_LINE = 8;
  localparam int PDCM_FIFO_DEPTH = 32;
  // I/O page starts at 248 Kbytes (top 8,192 bytes of 256 Kbytes)
  localparam logic [17:0] PDCM_IO_BASE = 18'h3e000;
  localparam logic [1:0] PDCM_LRU_RST = 2'h0;
  localparam logic [5:0] PDCM_RELOC_RST = 6'h00;
  typedef enum logic [1:0] {PDCM_CMD_READ, PDCM_CMD_WRITE, PDCM_CMD_IACK} pdcm_cmd_t;
endpackage

//--- core/pdcm_mi_if.sv
// Purpose: Multiplexed memory interconnect between adapter and memory side
// Assumes: One clock, adapter masters only while granted
// Notes: Address phase then one or more data beats
`timescale 1ns/100ps
interface pdcm_mi_if;
  logic req;
  logic gnt;
  logic addr_valid;
  logic [21:0] addr;
  logic io_page_select_n;
  logic write;
  logic [3:0] beats;
  logic [15:0] wdata;
  logic wvalid;
  logic [15:0] rdata;
  logic rvalid;
  logic done;
  modport adapter (output req, addr_valid, addr, io_page_select_n, write, beats, wdata, wvalid,
                   input gnt, rdata, rvalid, done);
  modport arbiter (input req, addr_valid, addr, io_page_select_n, write, beats, wdata, wvalid,
                   output gnt, rdata, rvalid, done);
endinterface

//--- core/pdcm_fifo.sv
// Purpose: Word FIFO between the interconnect and the peripheral side
// Assumes: Single clock
// Notes: Flip-flop storage indexed by pointer
`timescale 1ns/100ps
module pdcm_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  // Flush
  input wire logic flush_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  assign in_ready_out = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out = mem_r[rp_r];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_r[wp_r] <= in_data_in;
    end
  end
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (flush_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + AW'(1);
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // pdcm_fifo

//--- core/pdcm_adapter.sv
// Purpose: Peripheral DMA adapter with address map and four-set read cache
// Assumes: Peripheral requests held until ack; word addresses even
// Notes: Cache fills eight words per line-aligned read miss through the FIFO
`timescale 1ns/100ps
module pdcm_adapter
  import pdcm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Map control
  input wire logic map_control_register_reloc_in,
  input wire logic [5:0] reloc_base_in,
  // Peripheral DMA request
  input wire logic p_req_in,
  input wire pdcm_cmd_t p_cmd_in,
  input wire logic [17:0] p_addr_in,
  input wire logic [15:0] p_wdata_in,
  output logic p_ack_out,
  output logic [15:0] p_rdata_out,
  output logic p_default_master_out,
  // Interconnect
  pdcm_mi_if.adapter mi
);
  typedef enum {PDCM_IDLE, PDCM_REQ, PDCM_BUSY, PDCM_FILL, PDCM_ACK} pdcm_state_t;
  pdcm_state_t st_r;
  logic [15:0] data_r [PDCM_SETS][PDCM_LINE];
  logic [PDCM_SETS-1:0] valid_r;
  logic [17:0] tag_r [PDCM_SETS];
  logic [1:0] age_r [PDCM_SETS];
  logic [PDCM_SETS-1:0] hit;
  logic [1:0] hit_set;
  logic [1:0] victim;
  logic [1:0] fill_set_r;
  logic [2:0] fill_idx_r;
  logic [17:0] line_addr;
  logic is_io;
  logic cacheable;
  logic [21:0] maddr;
  logic f_valid;
  logic f_ready;
  logic [15:0] f_data;
  logic f_pop;
  logic f_flush;
  logic f_in_ready;
  logic touch;
  assign line_addr = {p_addr_in[17:4], 4'h0};
  assign is_io = (p_addr_in >= PDCM_IO_BASE);
  assign cacheable = !is_io && (p_cmd_in == PDCM_CMD_READ) && (p_addr_in[3:0] == 4'h0);
  // Address map with relocation, lower space only
  always_comb begin
    maddr = {4'h0, p_addr_in};
    if (is_io) begin
      maddr = {4'hf, p_addr_in};
    end else if (map_control_register_reloc_in) begin
      maddr = {reloc_base_in, 16'h0000} + {4'h0, p_addr_in};
    end
  end
  always_comb begin
    hit_set = 2'h0;
    victim = 2'h0;
    for (int i = 0; i < PDCM_SETS; i++) begin
      hit[i] = valid_r[i] && (tag_r[i] == line_addr) && !is_io;
      if (hit[i]) begin
        hit_set = 2'(i);
      end
    end
    for (int i = 0; i < PDCM_SETS; i++) begin
      if (age_r[i] == 2'h3) begin
        victim = 2'(i);
      end
    end
    for (int i = PDCM_SETS - 1; i >= 0; i--) begin
      if (!valid_r[i]) begin
        victim = 2'(i);
      end
    end
  end
  assign f_ready = (st_r == PDCM_FILL);
  assign f_pop = f_valid && f_ready;
  assign f_flush = 1'b0;
  pdcm_fifo #(.WIDTH(PDCM_DW), .DEPTH(PDCM_FIFO_DEPTH)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .in_valid_in(mi.rvalid && (st_r == PDCM_BUSY || st_r == PDCM_FILL) && !mi.write),
    .in_ready_out(f_in_ready),
    .in_data_in(mi.rdata),
    .out_valid_out(f_valid),
    .out_ready_in(f_ready),
    .out_data_out(f_data),
    .flush_in(f_flush)
  );
  assign touch = (st_r == PDCM_IDLE) && p_req_in && !p_ack_out && (p_cmd_in == PDCM_CMD_READ) && (|hit);
  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= PDCM_IDLE;
      mi.req <= 1'b0;
      mi.addr_valid <= 1'b0;
      mi.addr <= '0;
      mi.io_page_select_n <= 1'b1;
      mi.write <= 1'b0;
      mi.beats <= 4'h0;
      mi.wdata <= '0;
      mi.wvalid <= 1'b0;
      p_ack_out <= 1'b0;
      p_rdata_out <= '0;
      p_default_master_out <= 1'b1;
      fill_set_r <= 2'h0;
      fill_idx_r <= 3'h0;
    end else begin
      p_ack_out <= 1'b0;
      mi.addr_valid <= 1'b0;
      mi.wvalid <= 1'b0;
      unique case (st_r)
        PDCM_IDLE: begin
          if (p_req_in && !p_ack_out) begin
            if (p_cmd_in == PDCM_CMD_READ && (|hit)) begin
              p_rdata_out <= data_r[hit_set][p_addr_in[3:1]];
              p_ack_out <= 1'b1;
            end else begin
              // Adapter requests mastership, covers vector transfers
              mi.req <= 1'b1;
              mi.addr <= maddr;
              // Select line low for I/O page
              mi.io_page_select_n <= !is_io;
              mi.write <= (p_cmd_in == PDCM_CMD_WRITE);
              mi.wdata <= p_wdata_in;
              mi.beats <= cacheable ? 4'h8 : 4'h1;
              fill_set_r <= victim;
              fill_idx_r <= 3'h0;
              st_r <= PDCM_REQ;
            end
          end
        end
        PDCM_REQ: begin
          // Wait for grant from default master
          if (mi.gnt) begin
            mi.addr_valid <= 1'b1;
            mi.wvalid <= mi.write;
            st_r <= PDCM_BUSY;
          end
        end
        PDCM_BUSY: begin
          if (mi.done) begin
            mi.req <= 1'b0;
            st_r <= mi.write ? PDCM_ACK : PDCM_FILL;
          end
        end
        PDCM_FILL: begin
          if (f_pop) begin
            fill_idx_r <= fill_idx_r + 3'h1;
            if (fill_idx_r == 3'h0) begin
              p_rdata_out <= f_data;
            end
            if (fill_idx_r == 3'(mi.beats - 4'h1)) begin
              st_r <= PDCM_ACK;
            end
          end
        end
        PDCM_ACK: begin
          p_ack_out <= 1'b1;
          st_r <= PDCM_IDLE;
        end
        default: st_r <= PDCM_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Cache data storage, beats land in order
  always_ff @(posedge clk_sys_in) begin
    if (f_pop && mi.beats == 4'h8) begin
      data_r[fill_set_r][fill_idx_r] <= f_data;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Tags and valid handled by hardware only
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      valid_r <= '0;
      for (int i = 0; i < PDCM_SETS; i++) begin
        tag_r[i] <= '0;
      end
    end else begin
      if (st_r == PDCM_IDLE && p_req_in && !p_ack_out && p_cmd_in == PDCM_CMD_WRITE) begin
        valid_r <= valid_r & ~hit;
      end
      if (st_r == PDCM_FILL && f_pop && fill_idx_r == 3'h7 && mi.beats == 4'h8) begin
        valid_r[fill_set_r] <= 1'b1;
        tag_r[fill_set_r] <= line_addr;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Age tracking per set
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < PDCM_SETS; i++) begin
        age_r[i] <= 2'(i);
      end
    end else if (touch || (st_r == PDCM_FILL && f_pop && fill_idx_r == 3'h7 && mi.beats == 4'h8)) begin
      for (int i = 0; i < PDCM_SETS; i++) begin
        if (2'(i) == (touch ? hit_set : fill_set_r)) begin
          age_r[i] <= PDCM_LRU_RST;
        end else if (age_r[i] < age_r[touch ? hit_set : fill_set_r]) begin
          age_r[i] <= age_r[i] + 2'h1;
        end
      end
    end
  end
endmodule // pdcm_adapter

//--- core/pdcm_memside.sv
// Purpose: Interconnect arbiter and memory responder
// Assumes: CPU requests by a plain input; memory in flip-flops
// Notes: Reads are delivered as consecutive beats after one address
`timescale 1ns/100ps
module pdcm_memside
  import pdcm_pkg::*;
#(
  parameter int MEM_WORDS = 256
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // CPU side
  input wire logic cpu_req_in,
  output logic cpu_master_out,
  output logic io_access_out,
  // Interconnect
  pdcm_mi_if.arbiter mi
);
  localparam int AW = $clog2(MEM_WORDS);
  logic [15:0] mem_r [MEM_WORDS];
  logic active_r;
  logic [3:0] left_r;
  logic [AW-1:0] ptr_r;
  // CPU default master, adapter only other master
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      mi.gnt <= 1'b0;
      cpu_master_out <= 1'b1;
    end else begin
      mi.gnt <= mi.req && !(cpu_req_in && !mi.gnt);
      cpu_master_out <= !(mi.req && !(cpu_req_in && !mi.gnt));
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // One address, consecutive beats
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      active_r <= 1'b0;
      left_r <= 4'h0;
      ptr_r <= '0;
      mi.rdata <= '0;
      mi.rvalid <= 1'b0;
      mi.done <= 1'b0;
      io_access_out <= 1'b0;
    end else begin
      mi.rvalid <= 1'b0;
      mi.done <= 1'b0;
      if (mi.addr_valid) begin
        active_r <= 1'b1;
        left_r <= mi.beats;
        ptr_r <= mi.addr[AW:1];
        io_access_out <= !mi.io_page_select_n;
      end else if (active_r) begin
        if (!mi.write) begin
          mi.rdata <= mi.io_page_select_n ? mem_r[ptr_r] : 16'h0000;
          mi.rvalid <= 1'b1;
        end
        ptr_r <= ptr_r + AW'(1);
        left_r <= left_r - 4'h1;
        if (left_r == 4'h1 || mi.write) begin
          active_r <= 1'b0;
          mi.done <= 1'b1;
        end
      end
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (active_r && mi.write && mi.io_page_select_n) begin
      mem_r[ptr_r] <= mi.wdata;
    end
  end
endmodule // pdcm_memside

//--- tb/pdcm_monitor.sv
// Purpose: Interconnect protocol checks for the DMA bridge
// Assumes: One clock, sampled on rising edge
// Notes: Sees only the interface signals
`timescale 1ns/100ps
module pdcm_monitor (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Interconnect
  input wire logic req_in,
  input wire logic gnt_in,
  input wire logic addr_valid_in,
  input wire logic [21:0] addr_in,
  input wire logic io_page_select_n_in,
  input wire logic write_in,
  input wire logic [3:0] beats_in,
  input wire logic rvalid_in,
  input wire logic done_in
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////
  a_grant_before_addr: assert property (addr_valid_in |-> gnt_in && req_in)
    else $error("address phase without grant");
  a_io_page_addr: assert property (addr_valid_in && !io_page_select_n_in |-> addr_in[21:13] == 9'h1ff && beats_in == 4'h1)
    else $error("I/O page access malformed");
  a_beats_legal: assert property (addr_valid_in |-> beats_in == 4'h1 || beats_in == 4'h8)
    else $error("illegal beat count");
  a_burst_aligned: assert property (addr_valid_in && beats_in == 4'h8 |-> addr_in[3:0] == 4'h0 && !write_in && io_page_select_n_in)
    else $error("block read misaligned");
  a_burst_beats: assert property (addr_valid_in && beats_in == 4'h8 |-> ##2 rvalid_in [*8])
    else $error("block read beats not consecutive");
  a_burst_done: assert property (addr_valid_in && beats_in == 4'h8 |=> !done_in [*8] ##1 done_in)
    else $error("block read done misplaced");
  a_single_read: assert property (addr_valid_in && beats_in == 4'h1 && !write_in |-> ##2 rvalid_in && done_in)
    else $error("single read not answered");
  a_write_done: assert property (addr_valid_in && write_in |-> ##2 done_in && !rvalid_in)
    else $error("write not completed");
  a_one_address: assert property (addr_valid_in && beats_in == 4'h8 |=> !addr_valid_in [*8])
    else $error("second address inside block");
endmodule // pdcm_monitor

//--- tb/peripheral_dma_cache_and_map_tb.sv
// Purpose: Self-checking bench for adapter, memory side and FIFO
// Assumes: Memory side indexes words by address bits 8:1
// Notes: Expected results queued by driver, compared by watcher
`timescale 1ns/100ps
module peripheral_dma_cache_and_map_tb;
  import pdcm_pkg::*;
  logic clk_sys_in = 0, rst_in = 1, reloc = 0, cpu_req = 0, p_req = 0;
  pdcm_cmd_t p_cmd = PDCM_CMD_READ;
  logic [5:0] base = 6'h00;
  logic [17:0] p_addr = 18'h0;
  logic [15:0] p_wd = 16'h0, p_rd;
  logic [15:0] mem_m [256];
  logic p_ack, dflt, cpu_m, io_acc;
  logic [26:0] q_mi [$];
  logic [16:0] q_rd [$];
  logic [16:0] e_rd;
  int fail_count = 0, checks = 0, i, j, rv_n = 0;
  always #25 clk_sys_in = ~clk_sys_in;
  ////////////////////////////////////////////////////////////////
  pdcm_mi_if mi ();
  pdcm_adapter i_pdcm_adapter (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .map_control_register_reloc_in(reloc),
    .reloc_base_in(base), .p_req_in(p_req), .p_cmd_in(p_cmd), .p_addr_in(p_addr), .p_wdata_in(p_wd),
    .p_ack_out(p_ack), .p_rdata_out(p_rd), .p_default_master_out(dflt), .mi(mi));
  pdcm_memside i_pdcm_memside (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cpu_req_in(cpu_req),
    .cpu_master_out(cpu_m), .io_access_out(io_acc), .mi(mi));
  pdcm_monitor i_pdcm_monitor (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .req_in(mi.req), .gnt_in(mi.gnt),
    .addr_valid_in(mi.addr_valid), .addr_in(mi.addr), .io_page_select_n_in(mi.io_page_select_n),
    .write_in(mi.write), .beats_in(mi.beats), .rvalid_in(mi.rvalid), .done_in(mi.done));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic acc(input pdcm_cmd_t c, input logic [17:0] a, input logic [15:0] d, input logic on,
                     input logic [3:0] nb);
    logic io;
    logic [21:0] ma;
    int k;
    io = a >= PDCM_IO_BASE;
    ma = io ? {4'hf, a} : {4'h0, a} + (reloc ? {base, 16'h0} : 22'h0);
    if (on) q_mi.push_back({~io, nb, ma});
    if (c == PDCM_CMD_WRITE) begin
      q_rd.push_back(17'h0);
      if (!io) mem_m[a[8:1]] = d;
    end else q_rd.push_back({1'b1, io ? 16'h0 : mem_m[a[8:1]]});
    @(posedge clk_sys_in);
    p_req <= 1'b1;
    p_cmd <= c;
    p_addr <= a;
    p_wd <= d;
    k = 0;
    do begin
      @(negedge clk_sys_in);
      k++;
    end while (p_ack !== 1'b1 && k < 300);
    if (p_ack !== 1'b1) begin
      fail_count++;
      stop_test();
    end
    @(posedge clk_sys_in);
    p_req <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(negedge clk_sys_in) begin
    if (!rst_in && mi.rvalid) rv_n++;
    if (!rst_in && mi.addr_valid) begin
      if (q_mi.size() == 0) chk("mi_extra", 1, 0);
      else chk("mi_addr", {mi.io_page_select_n, mi.beats, mi.addr}, q_mi.pop_front());
    end
    if (!rst_in && p_ack === 1'b1) begin
      e_rd = q_rd.size() ? q_rd.pop_front() : 17'h1ffff;
      if (e_rd[16]) chk("rdata", p_rd, e_rd[15:0]);
    end
  end
  initial begin
    void'($urandom(45));
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(negedge clk_sys_in);
    chk("dflt", dflt, 1);
    chk("cpu_m", cpu_m, 1);
    for (i = 0; i < 48; i++) acc(PDCM_CMD_WRITE, 18'(i * 2), 16'($urandom), 1, 4'h1);
    $display("test writes done");
    cpu_req <= 1'b1;
    fork
      begin
        repeat (5) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk("cpu_m_hold", cpu_m, 1);
        @(posedge clk_sys_in);
        cpu_req <= 1'b0;
      end
    join_none
    for (i = 0; i < 4; i++) acc(PDCM_CMD_READ, 18'(i * 16), 0, 1, 4'h8);
    for (i = 1; i < 8; i++) for (j = 0; j < 4; j++) acc(PDCM_CMD_READ, 18'(j * 16 + i * 2), 0, 0, 0);
    $display("test cache done");
    acc(PDCM_CMD_WRITE, 18'h4, 16'($urandom), 1, 4'h1);
    acc(PDCM_CMD_READ, 18'h4, 0, 1, 4'h1);
    acc(PDCM_CMD_READ, 18'h6, 0, 1, 4'h1);
    acc(PDCM_CMD_READ, 18'h40, 0, 1, 4'h8);
    acc(PDCM_CMD_READ, 18'h12, 0, 0, 0);
    acc(PDCM_CMD_READ, 18'h22, 0, 0, 0);
    acc(PDCM_CMD_READ, 18'h42, 0, 0, 0);
    acc(PDCM_CMD_READ, 18'h50, 0, 1, 4'h8);
    acc(PDCM_CMD_READ, 18'h32, 0, 1, 4'h1);
    acc(PDCM_CMD_READ, 18'h14, 0, 0, 0);
    $display("test replace done");
    acc(PDCM_CMD_READ, 18'h3e000, 0, 1, 4'h1);
    acc(PDCM_CMD_READ, 18'h3e000, 0, 1, 4'h1);
    acc(PDCM_CMD_WRITE, 18'h3fffe, 16'($urandom), 1, 4'h1);
    chk("io_acc", io_acc, 1);
    acc(PDCM_CMD_WRITE, 18'h3dffe, 16'($urandom), 1, 4'h1);
    acc(PDCM_CMD_IACK, 18'h20, 0, 1, 4'h1);
    $display("test io page done");
    reloc <= 1'b1;
    base <= 6'($urandom);
    @(negedge clk_sys_in);
    acc(PDCM_CMD_WRITE, 18'h180, 16'($urandom), 1, 4'h1);
    acc(PDCM_CMD_READ, 18'h180, 0, 1, 4'h8);
    reloc <= 1'b0;
    @(negedge clk_sys_in);
    chk("mi_left", q_mi.size(), 0);
    $display("test relocation done");
    for (i = 0; i < 8; i++) acc(PDCM_CMD_WRITE, 18'(32 + i * 2), 16'($urandom), 1, 4'h1);
    rv_n = 0;
    acc(PDCM_CMD_READ, 18'h20, 0, 1, 4'h8);
    chk("blk_beats", rv_n, 8);
    for (i = 1; i < 8; i++) begin
      acc(PDCM_CMD_READ, 18'(32 + i * 2), 0, 0, 0);
      chk("blk_word", p_rd, mem_m[16 + i]);
    end
    chk("blk_left", q_mi.size(), 0);
    $display("test block done");
    stop_test();
  end
endmodule // peripheral_dma_cache_and_map_tb
